// ==== bit_logic_execute_unit.sv ====
// execute datapath for byte AND and single-bit operations
`timescale 1ns/1ps
`default_nettype none
module bit_logic_execute_unit (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic ce_i,
	input wire logic issue_i,
	input wire logic [7:0] opcode_i,
	input wire logic [7:0] operand_byte_i,
	input wire logic [7:0] dst_value_i,
	input wire logic [7:0] src_value_i,
	input wire logic [7:0] relative_displacement_i,
	input wire logic [15:0] pc_next_i,
	input wire logic [3:0] cond_code_i,
	input wire logic [7:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [7:0] reg_rdata_o,
	output logic [7:0] result_o,
	output logic result_we_o,
	output logic [15:0] pc_o,
	output logic pc_load_o,
	output logic done_o,
	output logic [3:0] cycles_o,
	output logic cond_true_o,
	output logic [7:0] condition_flags_o
);
	import bit_logic_pkg::*;

	logic [7:0] condition_flags;
	logic [7:0] next_flags;
	logic [7:0] next_result;
	logic next_we;
	logic next_pc_load;
	logic [3:0] next_cycles;
	logic next_valid;

	function automatic logic [7:0] put_bit(input logic [7:0] v,
		input logic [2:0] idx, input logic b);
		logic [7:0] r;
		r = v;
		r[idx] = b;
		return r;
	endfunction

	wire [2:0] bit_idx = operand_byte_i[BIT_HI:BIT_LO];
	wire dir_bit = operand_byte_i[DIR_POS];
	wire is_and = (opcode_i == OPC_AND_RR) || (opcode_i == OPC_AND_RIR) ||
		(opcode_i == OPC_AND_REG) || (opcode_i == OPC_AND_IR) ||
		(opcode_i == OPC_AND_IM);
	wire is_band = opcode_i == OPC_BIT_AND;
	wire is_bor = opcode_i == OPC_BIT_OR;
	wire is_bcp = opcode_i == OPC_BIT_CMP;
	wire is_binv = opcode_i == OPC_BIT_INV;
	wire is_bcs = opcode_i == OPC_BIT_CLRSET;
	wire is_br = opcode_i == OPC_BRANCH_LOW;
	wire [7:0] and_res = dst_value_i & src_value_i;
	// dir 0: working bit0 is dst, other operand bit idx is src
	wire merge_src = dir_bit ? src_value_i[0] : src_value_i[bit_idx];
	wire merge_dst = dir_bit ? dst_value_i[bit_idx] : dst_value_i[0];
	wire [2:0] merge_pos = dir_bit ? bit_idx : 3'h0;
	wire merge_bit = is_band ? (merge_dst & merge_src) :
		(merge_dst | merge_src);
	wire [7:0] merge_res = put_bit(dst_value_i, merge_pos, merge_bit);
	wire inv_bit = ~dst_value_i[bit_idx];
	wire [7:0] inv_res = put_bit(dst_value_i, bit_idx, inv_bit);
	wire [7:0] cs_res = put_bit(dst_value_i, bit_idx, dir_bit);
	wire tested = src_value_i[bit_idx];
	wire [15:0] disp_ext = {{8{relative_displacement_i[7]}},
		relative_displacement_i};
	wire [15:0] target = 16'(pc_next_i + disp_ext);
	wire flags_sel = reg_addr_i == FLAGS_ADDR;
	wire flag_c = condition_flags[FLAG_C];
	wire flag_z = condition_flags[FLAG_Z];
	wire flag_s = condition_flags[FLAG_S];
	wire flag_v = condition_flags[FLAG_V];
	wire sv = flag_s ^ flag_v;
	logic cond_eval;

	always_comb begin
		case (cond_code_i[2:0])
			3'h0: cond_eval = 1'b0;
			3'h1: cond_eval = sv;
			3'h2: cond_eval = flag_z | sv;
			3'h3: cond_eval = flag_c | flag_z;
			3'h4: cond_eval = flag_v;
			3'h5: cond_eval = flag_s;
			3'h6: cond_eval = flag_z;
			3'h7: cond_eval = flag_c;
			default: cond_eval = 1'b0;
		endcase
	end

	always_comb begin
		next_flags = condition_flags;
		next_result = dst_value_i;
		next_we = 1'b0;
		next_pc_load = 1'b0;
		next_cycles = CYC_LONG;
		next_valid = 1'b1;
		if (is_and) begin
			next_result = and_res;
			next_we = 1'b1;
			next_cycles = (opcode_i == OPC_AND_RR) ? CYC_SHORT : CYC_LONG;
			next_flags[FLAG_Z] = and_res == 8'h00;
			next_flags[FLAG_S] = and_res[7];
			next_flags[FLAG_V] = 1'b0;
		end else if (is_band || is_bor) begin
			next_result = merge_res;
			next_we = 1'b1;
			// zero looks at the whole written byte, not the merged bit
			next_flags[FLAG_Z] = merge_res == 8'h00;
			next_flags[FLAG_S] = 1'b0;
		end else if (is_bcp) begin
			next_flags[FLAG_Z] = src_value_i[bit_idx] == dst_value_i[0];
			next_flags[FLAG_S] = 1'b0;
		end else if (is_binv) begin
			next_result = inv_res;
			next_we = 1'b1;
			next_cycles = CYC_SHORT;
			next_flags[FLAG_Z] = inv_res == 8'h00;
			next_flags[FLAG_S] = 1'b0;
		end else if (is_bcs) begin
			next_result = cs_res;
			next_we = 1'b1;
			next_cycles = CYC_SHORT;
		end else if (is_br) begin
			next_pc_load = ~tested;
			next_cycles = CYC_BRANCH;
		end else begin
			next_valid = 1'b0;
		end
	end

	wire exec = ce_i && issue_i && next_valid;
	// flag port write at this edge; it outranks any issue
	wire flag_wr = ce_i && reg_wr_i && flags_sel;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			condition_flags <= FLAGS_RESET;
		end else if (ce_i) begin
			if (reg_wr_i && flags_sel) begin
				condition_flags <= reg_wdata_i;
			end else if (exec) begin
				condition_flags <= next_flags;
			end
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			result_o <= 8'h00;
			result_we_o <= 1'b0;
			pc_o <= 16'h0000;
			pc_load_o <= 1'b0;
			done_o <= 1'b0;
			cycles_o <= 4'h0;
		end else if (ce_i) begin
			result_o <= next_result;
			result_we_o <= exec && next_we;
			pc_o <= next_pc_load ? target : pc_next_i;
			pc_load_o <= exec && next_pc_load;
			done_o <= exec;
			cycles_o <= next_cycles;
		end
	end

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
			cond_true_o <= 1'b0;
			condition_flags_o <= FLAGS_RESET;
		end else if (ce_i) begin
			reg_rdata_o <= (reg_rd_i && flags_sel) ? condition_flags : 8'h00;
			cond_true_o <= cond_eval ^ cond_code_i[3];
			condition_flags_o <= (reg_wr_i && flags_sel) ? reg_wdata_i :
				(exec ? next_flags : condition_flags);
		end
	end

	chk_bitset_flags: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_bcs && !reg_wr_i) |=> $stable(condition_flags))
		else $error("bit clear/set changed flags");
	chk_branch_taken: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_br && !tested) |=> pc_load_o &&
		pc_o == $past(target)) else $error("branch not taken");
	chk_branch_fall: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_br && tested) |=> !pc_load_o && !result_we_o)
		else $error("branch taken on high bit");
	chk_and_result: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_and) |=> result_we_o &&
		result_o == ($past(dst_value_i) & $past(src_value_i)))
		else $error("byte AND result wrong");
	chk_and_zflag: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_and && !reg_wr_i) |=>
		condition_flags[FLAG_Z] == (result_o == 8'h00) &&
		condition_flags[FLAG_S] == result_o[7] && !condition_flags[FLAG_V])
		else $error("byte AND flags wrong");
	chk_merge_other: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && (is_band || is_bor)) |=>
		((result_o ^ $past(dst_value_i)) & ~(8'h01 << $past(merge_pos))) == 8'h00)
		else $error("merge touched other bits");
	chk_cmp_nowrite: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_bcp && !reg_wr_i) |=> !result_we_o &&
		condition_flags[FLAG_Z] == ($past(src_value_i[bit_idx]) ==
		$past(dst_value_i[0]))) else $error("bit compare wrong");
	chk_invert_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_binv) |=> result_o == ($past(dst_value_i) ^
		(8'h01 << $past(bit_idx))) && cycles_o == CYC_SHORT)
		else $error("bit invert wrong");
	chk_clrset_bit: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && is_bcs) |=>
		result_o[$past(bit_idx)] == $past(dir_bit)) else $error("clr/set wrong");
	chk_bitop_sign: assert property (@(posedge clk_i) disable iff (rst_i)
		(ce_i && issue_i && (is_band || is_bor || is_binv) && !reg_wr_i) |=>
		!condition_flags[FLAG_S] && $stable(condition_flags[FLAG_C]))
		else $error("bit op sign flag wrong");

	// taking edges per family; all but clear/set leave out a same-cycle flag write
	// because it would win over the flag update being checked
	sequence band_low_seq;
		ce_i && issue_i && is_band && !dir_bit && !flag_wr;
	endsequence
	sequence bor_high_seq;
		ce_i && issue_i && is_bor && dir_bit && !flag_wr;
	endsequence
	sequence bitop_take_seq;
		ce_i && issue_i && (is_band || is_bor || is_binv) && !flag_wr;
	endsequence
	sequence bitop_flags_seq;
		condition_flags[FLAG_Z] == (result_o == 8'h00) &&
		!condition_flags[FLAG_S];
	endsequence
	sequence branch_take_seq;
		ce_i && issue_i && is_br && !flag_wr;
	endsequence
	sequence clrset_take_seq;
		ce_i && issue_i && is_bcs;
	endsequence

	chk_band_low: assert property (@(posedge clk_i)
		disable iff (rst_i) band_low_seq |=> result_o[0] ==
		$past(dst_value_i[0] & src_value_i[bit_idx]))
		else $error("bit AND into bit 0 wrong");
	chk_bor_high: assert property (@(posedge clk_i)
		disable iff (rst_i) bor_high_seq |=> result_o[$past(bit_idx)] ==
		$past(dst_value_i[bit_idx] | src_value_i[0]))
		else $error("bit OR into selected bit wrong");
	chk_dir_low: assert property (@(posedge clk_i)
		disable iff (rst_i) band_low_seq |=>
		result_o[7:1] == $past(dst_value_i[7:1]))
		else $error("low-side merge touched upper bits");
	chk_bitop_zero: assert property (@(posedge clk_i)
		disable iff (rst_i) bitop_take_seq |=> bitop_flags_seq)
		else $error("bit op zero or sign flag wrong");
	// undefined overflow is held so that every run repeats exactly
	chk_undef_hold: assert property (@(posedge clk_i)
		disable iff (rst_i) bitop_take_seq |=>
		$stable(condition_flags[FLAG_V]) &&
		$stable(condition_flags[FLAG_D]) &&
		$stable(condition_flags[FLAG_H]))
		else $error("bit op moved V, D or H");
	chk_and_keep: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && issue_i && is_and && !flag_wr) |=>
		$stable(condition_flags[FLAG_C]) &&
		$stable(condition_flags[FLAG_D]) &&
		$stable(condition_flags[FLAG_H]))
		else $error("byte AND moved C, D or H");
	chk_cmp_sign: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && issue_i && is_bcp && !flag_wr) |=>
		!condition_flags[FLAG_S] && $stable(condition_flags[FLAG_C]))
		else $error("bit compare sign or carry wrong");
	chk_clrset_other: assert property (@(posedge clk_i)
		disable iff (rst_i) clrset_take_seq |=> result_we_o &&
		((result_o ^ $past(dst_value_i)) &
		~(8'h01 << $past(bit_idx))) == 8'h00)
		else $error("clear/set touched other bits");
	chk_clrset_cycles: assert property (@(posedge clk_i)
		disable iff (rst_i) clrset_take_seq |=> cycles_o == CYC_SHORT)
		else $error("clear/set cycle count wrong");
	chk_branch_flags: assert property (@(posedge clk_i)
		disable iff (rst_i) branch_take_seq |=> $stable(condition_flags) &&
		!result_we_o && cycles_o == CYC_BRANCH)
		else $error("branch changed flags or wrote back");
	chk_branch_next: assert property (@(posedge clk_i)
		disable iff (rst_i) (branch_take_seq ##0 tested) |=>
		pc_o == $past(pc_next_i)) else $error("fall-through pc wrong");
	chk_flags_write: assert property (@(posedge clk_i)
		disable iff (rst_i) flag_wr |=> condition_flags == $past(reg_wdata_i))
		else $error("flag register write lost");
	chk_flags_read: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && reg_rd_i && flags_sel) |=>
		reg_rdata_o == $past(condition_flags)) else $error("flag read wrong");
	// the output copy is a second flop, so it can drift if edited alone
	chk_flags_mirror: assert property (@(posedge clk_i)
		disable iff (rst_i) condition_flags_o == condition_flags)
		else $error("flag copy differs from flag register");
	chk_cond_zero: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && cond_code_i == 4'h6) |=>
		cond_true_o == $past(flag_z)) else $error("zero condition wrong");
	chk_bit_field: assert property (@(posedge clk_i)
		disable iff (rst_i) (ce_i && issue_i && is_binv) |=>
		(result_o ^ $past(dst_value_i)) ==
		(8'h01 << $past(operand_byte_i[3:1])))
		else $error("bit index decode wrong");
endmodule
`default_nettype wire

// ==== bit_logic_execute_unit_tb.sv ====
// self-checking bench for the bit logic execute unit
`timescale 1ns/1ps
`default_nettype none
module bit_logic_execute_unit_tb;
	import bit_logic_pkg::*;
	logic clk_i = 1'b0, rst_i = 1'b1, issue = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [7:0] opc = 8'h00, opb = 8'h00, dv = 8'h00, sv = 8'h00;
	logic [7:0] disp = 8'h00, addr = 8'h00, wdat = 8'h00;
	logic [15:0] pcn = 16'h0000;
	logic [3:0] cc = 4'h0;
	logic ce = 1'b1;
	// truth of condition code k with C=1 Z=0 S=1 V=0 sits in bit k
	logic [15:0] cond_mask = 16'h51AE;
	logic [7:0] rdat, res, flags, stored;
	logic we, pld, done, ctrue;
	logic [15:0] pc;
	logic [3:0] cyc;
	int error_cnt = 0, n_checks = 0, ticks = 0;
	bit_logic_execute_unit dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce),
		.issue_i(issue), .opcode_i(opc), .operand_byte_i(opb),
		.dst_value_i(dv), .src_value_i(sv), .relative_displacement_i(disp),
		.pc_next_i(pcn), .cond_code_i(cc), .reg_addr_i(addr),
		.reg_wdata_i(wdat), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
		.result_o(res), .result_we_o(we), .pc_o(pc), .pc_load_o(pld),
		.done_o(done), .cycles_o(cyc), .cond_true_o(ctrue),
		.condition_flags_o(flags));
	wb_model wb_u (.clk_i(clk_i), .rst_i(rst_i), .result_we_i(we),
		.result_i(res), .stored_o(stored));
	initial begin
		forever #50 clk_i = ~clk_i;
	end
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic check(input string what, input logic [15:0] seen, exp);
		n_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// issue lands one edge after launch; outputs read just past it
	task automatic exec(input logic [7:0] o, b, d, s);
		@(posedge clk_i);
		issue <= 1'b1;
		opc <= o;
		opb <= b;
		dv <= d;
		sv <= s;
		@(posedge clk_i);
		issue <= 1'b0;
		#1;
	endtask
	task automatic reg_access(input logic w, input logic [7:0] a, d);
		@(posedge clk_i);
		wr <= w;
		rd <= ~w;
		addr <= a;
		wdat <= d;
		@(posedge clk_i);
		wr <= 1'b0;
		rd <= 1'b0;
		#1;
	endtask
	always @(posedge clk_i) begin
		ticks++;
		if (ticks > 2000) begin
			error_cnt++;
			end_of_test();
		end
	end
	initial begin
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check("flags reset", flags, 8'h00);
		reg_access(1'b1, FLAGS_ADDR, 8'hDC);
		reg_access(1'b0, FLAGS_ADDR, 8'h00);
		check("flags read", rdat, 8'hDC);
		reg_access(1'b0, 8'h10, 8'h00);
		check("unmapped read", rdat, 8'h00);
		for (int i = 0; i < 5; i++) begin
			exec(8'(OPC_AND_RR + i), 8'h00, 8'h12, 8'h03);
			check("and result", res, 8'h02);
			check("and write", we, 1'b1);
			check("and flags", flags, 8'h8C);
		end
		check("and cycles", cyc, CYC_LONG);
		exec(OPC_AND_IM, 8'h00, 8'h80, 8'hF0);
		check("and sign", flags, 8'hAC);
		for (int k = 0; k < 16; k++) begin
			@(posedge clk_i);
			cc <= 4'(k);
			@(posedge clk_i);
			#1;
			check("cond code", ctrue, cond_mask[k]);
		end
		check("write back", stored, 8'h80);
		exec(OPC_BIT_INV, 8'h02, 8'h07, 8'h00);
		check("inv result", res, 8'h05);
		check("inv flags", flags, 8'h8C);
		check("inv cycles", cyc, CYC_SHORT);
		exec(OPC_BIT_AND, 8'h02, 8'h01, 8'h00);
		check("band low", res, 8'h00);
		check("band zero", flags, 8'hCC);
		exec(OPC_BIT_AND, 8'h03, 8'h07, 8'h06);
		check("band high", res, 8'h05);
		check("band flags", flags, 8'h8C);
		exec(OPC_BIT_OR, 8'h05, 8'h03, 8'h07);
		check("bor high", res, 8'h07);
		exec(OPC_BIT_CMP, 8'h02, 8'h07, 8'h03);
		check("bcp write", we, 1'b0);
		check("bcp flags", flags, 8'hCC);
		exec(OPC_BIT_CLRSET, 8'h02, 8'h07, 8'h00);
		check("clear bit", res, 8'h05);
		check("clear flags", flags, 8'hCC);
		exec(OPC_BIT_CLRSET, 8'h07, 8'h07, 8'h00);
		check("set bit", res, 8'h0F);
		check("set flags", flags, 8'hCC);
		@(posedge clk_i);
		pcn <= 16'h0100;
		disp <= 8'hFE;
		exec(OPC_BRANCH_LOW, 8'h02, 8'h00, 8'h05);
		check("taken load", pld, 1'b1);
		check("taken pc", pc, 16'h00FE);
		check("branch done", done, 1'b1);
		check("branch cycles", cyc, CYC_BRANCH);
		exec(OPC_BRANCH_LOW, 8'h02, 8'h00, 8'h07);
		check("fall load", pld, 1'b0);
		check("fall pc", pc, 16'h0100);
		check("fall flags", flags, 8'hCC);
		// flag write and issue on one edge: the write must win
		@(posedge clk_i);
		issue <= 1'b1;
		opc <= OPC_AND_IM;
		dv <= 8'h00;
		wr <= 1'b1;
		addr <= FLAGS_ADDR;
		wdat <= 8'h3C;
		@(posedge clk_i);
		issue <= 1'b0;
		wr <= 1'b0;
		#1;
		check("write wins", flags, 8'h3C);
		check("write wins done", done, 1'b1);
		exec(8'h00, 8'h00, 8'h00, 8'h00);
		check("unknown done", done, 1'b0);
		// enable low: an issue is not taken and all state holds
		@(posedge clk_i);
		ce <= 1'b0;
		issue <= 1'b1;
		opc <= OPC_BIT_INV;
		@(posedge clk_i);
		ce <= 1'b1;
		issue <= 1'b0;
		#1;
		check("frozen done", done, 1'b0);
		check("frozen cycles", cyc, CYC_LONG);
		check("frozen flags", flags, 8'h3C);
		// second reset in mid-run
		@(posedge clk_i);
		rst_i <= 1'b1;
		@(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check("rerun flags", flags, FLAGS_RESET);
		check("rerun pc", pc, 16'h0000);
		end_of_test();
	end
endmodule
`default_nettype wire

// ==== bit_logic_pkg.sv ====
// constants for the bit logic execute unit
package bit_logic_pkg;
	localparam logic [7:0] OPC_AND_RR = 8'h52;
	localparam logic [7:0] OPC_AND_RIR = 8'h53;
	localparam logic [7:0] OPC_AND_REG = 8'h54;
	localparam logic [7:0] OPC_AND_IR = 8'h55;
	localparam logic [7:0] OPC_AND_IM = 8'h56;
	localparam logic [7:0] OPC_BIT_AND = 8'h67;
	localparam logic [7:0] OPC_BIT_OR = 8'h07;
	localparam logic [7:0] OPC_BIT_CMP = 8'h17;
	localparam logic [7:0] OPC_BIT_INV = 8'h57;
	localparam logic [7:0] OPC_BIT_CLRSET = 8'h77;
	localparam logic [7:0] OPC_BRANCH_LOW = 8'h37;
	localparam logic [7:0] FLAGS_ADDR = 8'hD5;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	// flag positions inside the condition flag register
	localparam int FLAG_C = 7;
	localparam int FLAG_Z = 6;
	localparam int FLAG_S = 5;
	localparam int FLAG_V = 4;
	localparam int FLAG_D = 3;
	localparam int FLAG_H = 2;
	// second byte fields
	localparam int REG_HI = 7;
	localparam int REG_LO = 4;
	localparam int BIT_HI = 3;
	localparam int BIT_LO = 1;
	localparam int DIR_POS = 0;
	// cycle counts and condition code width
	localparam logic [3:0] CYC_SHORT = 4'h4;
	localparam logic [3:0] CYC_LONG = 4'h6;
	localparam logic [3:0] CYC_BRANCH = 4'hA;
	localparam logic [3:0] CC_WIDTH = 4'h4;
endpackage

// ==== wb_model.sv ====
// write-back model standing in for the register file
`timescale 1ns/1ps
`default_nettype none
module wb_model (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic result_we_i,
	input wire logic [7:0] result_i,
	output logic [7:0] stored_o
);
	// only a strobed result may land in the file
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			stored_o <= 8'h00;
		end else if (result_we_i) begin
			stored_o <= result_i;
		end
	end
endmodule
`default_nettype wire
